// file: design/seq_pkg.sv
// constants, timing and state type shared by the enable sequencer
package seq_pkg;

  localparam int NUM_CORES = 4;
  localparam int VSET_W    = 8;
  localparam int DELAY_W   = 4;
  localparam int SLEW_W    = 3;
  localparam int NUM_PINS  = 2;

  localparam int CLK_MHZ = 100;

  localparam int POR_TIME_NS     = 10000;
  localparam int POR_CYCLES      = (POR_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int OTP_LOAD_CYCLES = 16;
  localparam int SEQ_CNT_W       = 12;

  // short-circuit check window after enable
  localparam int SC_TIME_US         = 1000;
  localparam int SC_TIMEOUT_DEFAULT = SC_TIME_US * CLK_MHZ;
  localparam int SC_CNT_W           = 24;

  // one delay code step; counted exactly, so well inside +/-10 %
  localparam int DELAY_STEP_US      = 500;
  localparam int DELAY_STEP_DEFAULT = DELAY_STEP_US * CLK_MHZ;
  localparam int DELAY_CNT_W        = 24;

  // setpoint code after soft-start and per-code voltage step
  localparam logic [7:0] VSET_START = 8'h00;
  localparam int         VSTEP_UV   = 10000;
  localparam int         SLEW_CNT_W = 12;

  // cycles per setpoint step for each slew code, rates in uV/us
  function automatic int slew_period(input logic [2:0] code);
    int rate;
    case (code)
      3'h0:    rate = 30000;
      3'h1:    rate = 15000;
      3'h2:    rate = 10000;
      3'h3:    rate = 7500;
      3'h4:    rate = 3800;
      3'h5:    rate = 1900;
      3'h6:    rate = 940;
      default: rate = 400;
    endcase
    slew_period = (VSTEP_UV * CLK_MHZ) / rate;
  endfunction : slew_period

  typedef enum logic [2:0] {
    st_off,
    st_por,
    st_otp,
    st_standby,
    st_active
  } dev_state_t;

endpackage : seq_pkg

// file: design/slew_limiter.sv
// one core's slew-limited voltage setpoint ramp
module slew_limiter (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // control
  input  wire logic       run,
  input  wire logic [7:0] target,
  input  wire logic [2:0] rate,
  // setpoint
  output logic      [7:0] level,
  output logic            moving
);

  logic [seq_pkg::SLEW_CNT_W-1:0] tick_cnt_reg;
  logic [7:0]                     level_reg;
  logic [seq_pkg::SLEW_CNT_W-1:0] period;

  assign period = seq_pkg::SLEW_CNT_W'(seq_pkg::slew_period(rate));
  assign level  = level_reg;
  assign moving = run && (level_reg != target);

  // one code per period while run is high; run low puts level back to VSET_START at once
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      level_reg    <= seq_pkg::VSET_START;
      tick_cnt_reg <= '0;
    end
    else if (!run)
    begin
      level_reg    <= seq_pkg::VSET_START;
      tick_cnt_reg <= '0;
    end
    else if (level_reg != target)
    begin
      if (tick_cnt_reg >= period - 1'b1)
      begin
        tick_cnt_reg <= '0;
        if (level_reg < target)
          level_reg <= level_reg + 8'h01;
        else
          level_reg <= level_reg - 8'h01;
      end
      else
        tick_cnt_reg <= tick_cnt_reg + 1'b1;
    end
    else
      tick_cnt_reg <= '0;
  end

endmodule : slew_limiter

// file: design/buck_enable_sequencer.sv
// power-up, reset and per-core enable sequencing of a four-core buck
//
// Behaviour
// - reset release runs POR, OTP load, standby
// - cores enable only in standby or active
// - pin control off: enable bit alone, main setting
// - pin mode: selected pin low off, high on
// - per-core bit selects pin a or pin b
// - roof/floor: always on, pin picks floor/main
// - register enable changes take effect without delay
// - pin delays within ten percent of nominal
// - soft-start to 0.3 V, then slew control
// - below 0.35 V after 1 ms: off, flag
// - power-good flag per core, maskable interrupt
// - pin pull-downs on after reset, host disables
// - every voltage change while the core runs slew limited by field
// - forced PWM during change, then configured mode
// - soft reset: cores off, defaults, OTP, interface kept
// - reset pin or UVLO: cores off, defaults, restart
// - irq low while any unmasked flag pending
// - fault shutdown reported by reset flag at start-up
// - writing one clears an interrupt flag
// - slew code 000 fastest 30 mV/us, slower upward
module buck_enable_sequencer #(
  parameter int SC_TIMEOUT_CYCLES = seq_pkg::SC_TIMEOUT_DEFAULT,
  parameter int DELAY_STEP_CYCLES = seq_pkg::DELAY_STEP_DEFAULT
) (
  // clock and power-on reset
  input  wire logic            clk,
  input  wire logic            rst_n,
  // device pins and supply monitor
  input  wire logic            reset_in_n,
  input  wire logic            analog_supply,
  input  wire logic            fault_shutdown,
  input  wire logic            enable_pin_a,
  input  wire logic            enable_pin_b,
  output logic           [1:0] pin_pulldown_enable,
  output logic                 irq_out_n,
  // configuration bits
  input  wire logic      [3:0] core_enable_bit,
  input  wire logic      [3:0] pin_control_bit,
  input  wire logic      [3:0] roof_floor_bit,
  input  wire logic      [3:0] pin_select_bit,
  input  wire logic      [3:0] forced_pwm_bit,
  input  wire logic [3:0][7:0] main_voltage_setting,
  input  wire logic [3:0][7:0] floor_voltage_setting,
  input  wire logic [3:0][3:0] startup_delay_field,
  input  wire logic [3:0][3:0] shutdown_delay_field,
  input  wire logic [3:0][2:0] slew_rate_field,
  input  wire logic      [3:0] power_good_mask,
  input  wire logic      [1:0] pulldown_disable,
  input  wire logic            soft_reset_bit,
  // write-one-to-clear strobes for the flags
  input  wire logic      [3:0] power_good_clear,
  input  wire logic      [3:0] short_circuit_clear,
  input  wire logic            reset_flag_clear,
  // analog comparators per core
  input  wire logic      [3:0] above_soft_start_level,
  input  wire logic      [3:0] above_short_level,
  input  wire logic      [3:0] output_power_good,
  // core controls
  output logic           [3:0] core_on,
  output logic           [3:0] core_soft_start,
  output logic           [3:0] core_force_pwm,
  output logic      [3:0][7:0] core_setpoint,
  // status flags and device state
  output logic           [3:0] power_good_flag,
  output logic           [3:0] short_circuit_flag,
  output logic                 reset_flag,
  output logic                 interface_enable,
  output logic                 defaults_load,
  output logic                 otp_load,
  output logic                 device_ready
);

  seq_pkg::dev_state_t            state_reg;
  logic [seq_pkg::SEQ_CNT_W-1:0]  seq_cnt_reg;
  logic                           shutdown_req;
  logic                           ready;
  logic                           startup_done;
  logic                           interface_reg;
  logic                           defaults_reg;
  logic                           otp_reg;
  logic [1:0]                     pins_meta_reg;
  logic [1:0]                     pins_sync_reg;
  logic [3:0]                     on_reg;
  logic [3:0]                     ss_reg;
  logic [3:0]                     pg_flag_reg;
  logic [3:0]                     sc_flag_reg;
  logic [3:0]                     slewing;
  logic                           reset_flag_reg;
  logic                           irq_n_reg;

  assign shutdown_req = !reset_in_n || !analog_supply || fault_shutdown;
  assign ready        = (state_reg == seq_pkg::st_standby) ||
                        (state_reg == seq_pkg::st_active);
  assign startup_done = (state_reg == seq_pkg::st_otp) &&
    (seq_cnt_reg == seq_pkg::SEQ_CNT_W'(seq_pkg::OTP_LOAD_CYCLES - 1));

  // device sequence: off, POR, OTP load, standby/active
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg   <= seq_pkg::st_off;
      seq_cnt_reg <= '0;
    end
    else if (shutdown_req)
    begin
      state_reg   <= seq_pkg::st_off;
      seq_cnt_reg <= '0;
    end
    else if (soft_reset_bit)
    begin
      state_reg   <= seq_pkg::st_otp;
      seq_cnt_reg <= '0;
    end
    else
    begin
      case (state_reg)
        seq_pkg::st_off:
        begin
          state_reg   <= seq_pkg::st_por;
          seq_cnt_reg <= '0;
        end
        seq_pkg::st_por:
        begin
          if (seq_cnt_reg ==
              seq_pkg::SEQ_CNT_W'(seq_pkg::POR_CYCLES - 1))
          begin
            state_reg   <= seq_pkg::st_otp;
            seq_cnt_reg <= '0;
          end
          else
            seq_cnt_reg <= seq_cnt_reg + 1'b1;
        end
        seq_pkg::st_otp:
        begin
          if (startup_done)
          begin
            state_reg   <= seq_pkg::st_standby;
            seq_cnt_reg <= '0;
          end
          else
            seq_cnt_reg <= seq_cnt_reg + 1'b1;
        end
        seq_pkg::st_standby:
          if (|on_reg)
            state_reg <= seq_pkg::st_active;
        seq_pkg::st_active:
          if (!(|on_reg))
            state_reg <= seq_pkg::st_standby;
        default:
          state_reg <= seq_pkg::st_off;
      endcase
    end
  end

  // the serial interface survives a soft reset, not a pin or UVLO reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      interface_reg <= 1'b0;
    else if (shutdown_req)
      interface_reg <= 1'b0;
    else if (state_reg == seq_pkg::st_otp)
      interface_reg <= 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      defaults_reg <= 1'b1;
      otp_reg      <= 1'b0;
    end
    else
    begin
      defaults_reg <= shutdown_req || soft_reset_bit || !ready;
      otp_reg      <= !shutdown_req &&
                      (soft_reset_bit || (state_reg == seq_pkg::st_otp &&
                                          !startup_done));
    end
  end

  // two-flop synchroniser; only the second stage is looked at
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pins_meta_reg <= 2'h0;
      pins_sync_reg <= 2'h0;
    end
    else
    begin
      pins_meta_reg <= {enable_pin_b, enable_pin_a};
      pins_sync_reg <= pins_meta_reg;
    end
  end

  genvar i;
  generate
    for (i = 0; i < seq_pkg::NUM_CORES; i++)
    begin : g_core
      logic                                sel_pin;
      logic                                sel_prev_reg;
      logic                                pin_del_reg;
      logic                                pend_reg;
      logic                                pend_lvl_reg;
      logic [seq_pkg::DELAY_CNT_W-1:0]     dly_cnt_reg;
      logic [3:0]                          code;
      logic                                want_on;
      logic [seq_pkg::SC_CNT_W-1:0]        sc_cnt_reg;
      logic                                sc_ok_reg;
      logic                                sc_off_reg;
      logic                                pg_prev_reg;
      logic [7:0]                          target;
      logic                                sc_trip;

      assign sel_pin = pin_select_bit[i] ? pins_sync_reg[1]
                                         : pins_sync_reg[0];
      assign code    = sel_pin ? startup_delay_field[i]
                               : shutdown_delay_field[i];

      // pin level after the programmed start-up or shutdown delay
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          sel_prev_reg <= 1'b0;
          pin_del_reg  <= 1'b0;
          pend_reg     <= 1'b0;
          pend_lvl_reg <= 1'b0;
          dly_cnt_reg  <= '0;
        end
        else
        begin
          sel_prev_reg <= sel_pin;
          if (sel_pin != sel_prev_reg)
          begin
            // a new edge restarts the wait toward the new level
            if (code == 4'h0)
            begin
              pin_del_reg <= sel_pin;
              pend_reg    <= 1'b0;
            end
            else
            begin
              pend_reg     <= 1'b1;
              pend_lvl_reg <= sel_pin;
              dly_cnt_reg  <= seq_pkg::DELAY_CNT_W'(
                int'(code) * DELAY_STEP_CYCLES - 1);
            end
          end
          else if (pend_reg)
          begin
            if (dly_cnt_reg == '0)
            begin
              pin_del_reg <= pend_lvl_reg;
              pend_reg    <= 1'b0;
            end
            else
              dly_cnt_reg <= dly_cnt_reg - 1'b1;
          end
        end
      end

      // enable bit acts at once; only the pin path is delayed
      assign want_on = core_enable_bit[i] &&
        (!pin_control_bit[i] || roof_floor_bit[i] || pin_del_reg);
      assign target  = (pin_control_bit[i] && roof_floor_bit[i] &&
                        !pin_del_reg) ? floor_voltage_setting[i]
                                      : main_voltage_setting[i];
      assign sc_trip = on_reg[i] && !sc_ok_reg && !above_short_level[i] &&
        sc_cnt_reg == seq_pkg::SC_CNT_W'(SC_TIMEOUT_CYCLES - 1);

      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          on_reg[i] <= 1'b0;
        else
          on_reg[i] <= want_on && ready && !sc_off_reg && !sc_trip &&
                       !shutdown_req && !soft_reset_bit;
      end

      // soft-start until the output crosses the hand-over level
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          ss_reg[i] <= 1'b0;
        else if (!on_reg[i])
          ss_reg[i] <= 1'b1;
        else if (above_soft_start_level[i])
          ss_reg[i] <= 1'b0;
      end

      // start-up short check; the core stays off until re-requested
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          sc_cnt_reg <= '0;
          sc_ok_reg  <= 1'b0;
          sc_off_reg <= 1'b0;
        end
        else if (!want_on || !ready)
        begin
          sc_cnt_reg <= '0;
          sc_ok_reg  <= 1'b0;
          sc_off_reg <= 1'b0;
        end
        else if (on_reg[i] && !sc_ok_reg)
        begin
          if (above_short_level[i])
            sc_ok_reg <= 1'b1;
          else if (sc_trip)
            sc_off_reg <= 1'b1;
          else
            sc_cnt_reg <= sc_cnt_reg + 1'b1;
        end
      end

      // flags: a set in the cycle of a clear wins
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          pg_prev_reg    <= 1'b0;
          pg_flag_reg[i] <= 1'b0;
          sc_flag_reg[i] <= 1'b0;
        end
        else
        begin
          pg_prev_reg <= output_power_good[i] && on_reg[i];
          if (defaults_reg)
            pg_flag_reg[i] <= 1'b0;
          else if (output_power_good[i] && on_reg[i] && !pg_prev_reg)
            pg_flag_reg[i] <= 1'b1;
          else if (power_good_clear[i])
            pg_flag_reg[i] <= 1'b0;
          if (defaults_reg)
            sc_flag_reg[i] <= 1'b0;
          else if (sc_trip)
            sc_flag_reg[i] <= 1'b1;
          else if (short_circuit_clear[i])
            sc_flag_reg[i] <= 1'b0;
        end
      end

      slew_limiter u_slew (
        .clk    (clk),
        .rst_n  (rst_n),
        .run    (on_reg[i] && !ss_reg[i]),
        .target (target),
        .rate   (slew_rate_field[i]),
        .level  (core_setpoint[i]),
        .moving (slewing[i])
      );

      // during a ramp PWM is forced, afterwards the bit decides
      assign core_force_pwm[i] = forced_pwm_bit[i] || slewing[i];
    end
  endgenerate

  // reset flag reports every start-up, including one after a fault
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      reset_flag_reg <= 1'b0;
    else if (startup_done && !shutdown_req && !soft_reset_bit)
      reset_flag_reg <= 1'b1;
    else if (reset_flag_clear)
      reset_flag_reg <= 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irq_n_reg <= 1'b1;
    else
      irq_n_reg <= !((|(pg_flag_reg & ~power_good_mask)) ||
                     (|sc_flag_reg) || reset_flag_reg);
  end

  assign pin_pulldown_enable = ~pulldown_disable;
  assign irq_out_n           = irq_n_reg;
  assign core_on             = on_reg;
  assign core_soft_start     = ss_reg & on_reg;
  assign power_good_flag     = pg_flag_reg;
  assign short_circuit_flag  = sc_flag_reg;
  assign reset_flag          = reset_flag_reg;
  assign interface_enable    = interface_reg;
  assign defaults_load       = defaults_reg;
  assign otp_load            = otp_reg;
  assign device_ready        = ready;

endmodule : buck_enable_sequencer

// file: tb/seq_monitor.sv
// port-level assertions for the enable sequencer
module seq_monitor (
  // clock and reset
  input  wire logic            clk,
  input  wire logic            rst_n,
  // pins and configuration
  input  wire logic            reset_in_n,
  input  wire logic            analog_supply,
  input  wire logic            fault_shutdown,
  input  wire logic      [1:0] pulldown_disable,
  input  wire logic      [3:0] core_enable_bit,
  input  wire logic      [3:0] pin_control_bit,
  input  wire logic      [3:0] forced_pwm_bit,
  input  wire logic      [3:0] power_good_mask,
  input  wire logic            soft_reset_bit,
  // outputs
  input  wire logic      [1:0] pin_pulldown_enable,
  input  wire logic            irq_out_n,
  input  wire logic      [3:0] core_on,
  input  wire logic      [3:0] core_force_pwm,
  input  wire logic [3:0][7:0] core_setpoint,
  input  wire logic      [3:0] short_circuit_flag,
  input  wire logic      [3:0] power_good_flag,
  input  wire logic            reset_flag,
  input  wire logic            interface_enable,
  input  wire logic            otp_load,
  input  wire logic            device_ready
);
  default clocking mon_cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_pulldown_follow: assert property (
    pin_pulldown_enable == ~pulldown_disable)
    else $error("pull-down enable wrong");
  a_idle_cores_off: assert property (
    !device_ready |=> core_on == 4'h0)
    else $error("core on outside standby or active");
  a_bit_off_fast: assert property (
    (core_on & ~$past(core_enable_bit)) == 4'h0)
    else $error("core on without enable bit");
  a_bit_on_fast: assert property (
    $rose(core_enable_bit[1]) && !pin_control_bit[1] && device_ready
    && reset_in_n && analog_supply && !fault_shutdown && !soft_reset_bit
    |=> core_on[1])
    else $error("enable bit not applied next cycle");
  a_irq_tracks_flags: assert property (
    irq_out_n != $past(|{power_good_flag & ~power_good_mask,
                         short_circuit_flag, reset_flag}))
    else $error("interrupt pin disagrees with flags");
  a_short_trip_off: assert property (
    $rose(short_circuit_flag[0]) |-> !core_on[0] && $past(core_on[0]))
    else $error("short trip without core shutdown");
  a_soft_reset_off: assert property (
    soft_reset_bit && interface_enable
    |=> core_on == 4'h0 && otp_load && interface_enable)
    else $error("soft reset response wrong");
  a_reset_pin_off: assert property (
    !reset_in_n || !analog_supply || fault_shutdown
    |=> core_on == 4'h0 && !interface_enable && !device_ready)
    else $error("reset source did not stop the device");
  a_pwm_bit_on: assert property (
    forced_pwm_bit[3] |-> core_force_pwm[3])
    else $error("forced pwm bit ignored");
  a_step_in_pwm: assert property (
    core_on[3] && $past(core_on[3]) && $changed(core_setpoint[3])
    |-> $past(core_force_pwm[3]))
    else $error("setpoint moved outside forced pwm");
  a_step_one_code: assert property (
    core_on[3] && $past(core_on[3]) && $changed(core_setpoint[3])
    |-> 8'(core_setpoint[3] - $past(core_setpoint[3])) inside {8'h01, 8'hFF})
    else $error("setpoint jumped more than one code");
  a_ready_flag: assert property (
    $rose(device_ready) |-> reset_flag)
    else $error("start-up without reset flag");
endmodule : seq_monitor

bind buck_enable_sequencer seq_monitor u_seq_monitor (.*);

// file: tb/host_model.sv
// host-side model: drives the enable pins, holds off bus use
module host_model #(
  parameter int WAIT_CYCLES = 120000
) (
  // clock and reset pin
  input  wire logic       clk,
  input  wire logic       reset_in_n,
  // pin requests from the scenarios
  input  wire logic [1:0] pin_drive,
  input  wire logic [1:0] pin_level,
  input  wire logic [1:0] pin_pulldown_enable,
  // pin levels and bus permission
  output logic      [1:0] pin_wire,
  output logic            bus_ok
);
  timeunit 1ns;
  timeprecision 1ps;
  int   wait_cnt = 0;
  logic flip_reg = 1'b0;

  always_ff @(posedge clk)
  begin
    if (!reset_in_n)
      wait_cnt <= 0;
    else if (wait_cnt < WAIT_CYCLES)
      wait_cnt <= wait_cnt + 1;
  end
  assign bus_ok = (wait_cnt >= WAIT_CYCLES);

  always_ff @(posedge clk)
  begin
    flip_reg <= ~flip_reg;
  end

  // released pin: pull-down level, else a pattern that never settles
  always_comb
  begin
    for (int i = 0; i < 2; i++)
      pin_wire[i] = pin_drive[i] ? pin_level[i]
                  : (pin_pulldown_enable[i] ? 1'b0 : flip_reg);
  end
endmodule : host_model

// file: tb/tb.sv
// self-checking bench for the enable sequencer
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // short counts keep the run brief; expectations follow them
  localparam int SC_CYC   = 50;
  localparam int STEP_CYC = 10;
  localparam int HOLD     = 1200;
  logic            clk = 1'b0;
  logic            rst_n = 1'b0;
  logic            reset_in_n = 1'b1;
  logic            analog_supply = 1'b1;
  logic            fault_shutdown = 1'b0;
  logic      [1:0] pin_drive = 2'h3;
  logic      [1:0] pin_level = 2'h0;
  logic      [1:0] pin_wire;
  logic      [1:0] pulldown_disable = 2'h0;
  logic      [1:0] pin_pulldown_enable;
  logic      [3:0] core_enable_bit = 4'h0;
  logic      [3:0] pin_control_bit = 4'h0;
  logic      [3:0] roof_floor_bit = 4'h0;
  logic      [3:0] pin_select_bit = 4'h0;
  logic      [3:0] forced_pwm_bit = 4'h0;
  logic [3:0][7:0] main_voltage_setting = '0;
  logic [3:0][7:0] floor_voltage_setting = '0;
  logic [3:0][3:0] startup_delay_field = '0;
  logic [3:0][3:0] shutdown_delay_field = '0;
  logic [3:0][2:0] slew_rate_field = '0;
  logic      [3:0] power_good_mask = 4'h0;
  logic            soft_reset_bit = 1'b0;
  logic      [3:0] power_good_clear = 4'h0;
  logic      [3:0] short_circuit_clear = 4'h0;
  logic            reset_flag_clear = 1'b0;
  logic      [3:0] above_soft_start_level = 4'hF;
  logic      [3:0] above_short_level = 4'hF;
  logic      [3:0] output_power_good = 4'h0;
  logic      [3:0] core_on, core_soft_start, core_force_pwm;
  logic      [3:0] power_good_flag, short_circuit_flag;
  logic [3:0][7:0] core_setpoint;
  logic            irq_out_n, reset_flag, interface_enable;
  logic            defaults_load, otp_load, device_ready, bus_ok;
  int              err_total = 0;
  int              n_checks = 0;
  int              rate [8] = '{30000,15000,10000,7500,3800,1900,940,400};

  always #5 clk = ~clk;

  buck_enable_sequencer #(
    .SC_TIMEOUT_CYCLES(SC_CYC),
    .DELAY_STEP_CYCLES(STEP_CYC)
  ) u_buck_enable_sequencer (
    .enable_pin_a(pin_wire[0]),
    .enable_pin_b(pin_wire[1]),
    .*
  );
  host_model #(.WAIT_CYCLES(HOLD)) u_host_model (.*);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  task automatic wait_on(input int i, input logic lv, output int n);
    n = 0;
    while (core_on[i] !== lv && n < 400)
    begin
      @(negedge clk);
      n++;
    end
  endtask : wait_on

  task automatic wait_step(output int n);
    logic [7:0] old;
    old = core_setpoint[3];
    n = 0;
    while (core_setpoint[3] === old && n < 3000)
    begin
      @(negedge clk);
      n++;
    end
  endtask : wait_step

  // pin path adds sync and edge cycles on top of the coded delay
  task automatic chk_dly(input int code, input int n);
    chk(32'(n >= code * STEP_CYC * 9 / 10 + 2
        && n <= code * STEP_CYC * 11 / 10 + 5), 32'h1);
  endtask : chk_dly

  task automatic wait_up(input int lo);
    int n;
    n = 0;
    while (device_ready !== 1'b1 && n < 1100)
    begin
      chk(core_on, 4'h0);
      @(negedge clk);
      n++;
    end
    chk(32'(n >= lo - 2 && n <= lo + 3), 32'h1);
    chk({reset_flag, interface_enable, otp_load}, 3'h6);
    @(negedge clk);
    chk(irq_out_n, 1'b0);
    n = 0;
    while (bus_ok !== 1'b1 && n < 2000)
    begin
      @(negedge clk);
      n++;
    end
    reset_flag_clear = 1'b1;
    @(negedge clk);
    reset_flag_clear = 1'b0;
    chk(reset_flag, 1'b0);
    @(negedge clk);
    chk(irq_out_n, 1'b1);
  endtask : wait_up

  task automatic t_pulldown();
    chk(pin_pulldown_enable, 2'h3);
    pulldown_disable = 2'h2;
    @(negedge clk);
    chk(pin_pulldown_enable, 2'h1);
    pulldown_disable = 2'h0;
  endtask : t_pulldown

  task automatic t_reg();
    above_soft_start_level[1] = 1'b0;
    core_enable_bit[1] = 1'b1;
    @(negedge clk);
    chk(core_on[1], 1'b1);
    chk(core_soft_start[1], 1'b1);
    chk(core_setpoint[1], 8'h00);
    above_soft_start_level[1] = 1'b1;
    pin_level = 2'h3;
    cyc(2);
    chk(core_soft_start[1], 1'b0);
    chk(core_on[1], 1'b1);
    core_enable_bit[1] = 1'b0;
    pin_level = 2'h0;
    @(negedge clk);
    chk(core_on[1], 1'b0);
  endtask : t_reg

  task automatic t_pin();
    int n;
    pin_control_bit[2] = 1'b1;
    pin_select_bit[2] = 1'b1;
    startup_delay_field[2] = 4'hF;
    core_enable_bit[2] = 1'b1;
    pin_drive = 2'h1;
    pin_level = 2'h1;
    cyc(40);
    chk(core_on[2], 1'b0);
    pin_drive = 2'h3;
    pin_level = 2'h2;
    wait_on(2, 1'b1, n);
    chk_dly(15, n);
    shutdown_delay_field[2] = 4'h3;
    pin_level = 2'h0;
    wait_on(2, 1'b0, n);
    chk_dly(3, n);
    core_enable_bit[2] = 1'b0;
  endtask : t_pin

  task automatic t_roof();
    int n;
    floor_voltage_setting[3] = 8'h02;
    main_voltage_setting[3] = 8'h04;
    roof_floor_bit[3] = 1'b1;
    pin_control_bit[3] = 1'b1;
    core_enable_bit[3] = 1'b1;
    cyc(150);
    chk(core_on[3], 1'b1);
    chk(core_setpoint[3], 8'h02);
    chk(core_force_pwm[3], 1'b0);
    pin_level = 2'h1;
    cyc(10);
    chk(core_force_pwm[3], 1'b1);
    cyc(100);
    chk(core_setpoint[3], 8'h04);
    foreach (rate[c])
    begin
      slew_rate_field[3] = 3'(c);
      main_voltage_setting[3] = main_voltage_setting[3] + 8'h02;
      wait_step(n);
      wait_step(n);
      chk(n, 1000000 / rate[c]);
    end
    forced_pwm_bit[3] = 1'b1;
    @(negedge clk);
    chk(core_force_pwm[3], 1'b1);
  endtask : t_roof

  task automatic t_short();
    int n;
    above_short_level[0] = 1'b0;
    core_enable_bit[0] = 1'b1;
    @(negedge clk);
    chk(core_on[0], 1'b1);
    wait_on(0, 1'b0, n);
    chk(32'(n >= SC_CYC - 3 && n <= SC_CYC + 2), 32'h1);
    chk(short_circuit_flag[0], 1'b1);
    @(negedge clk);
    chk(irq_out_n, 1'b0);
    core_enable_bit[0] = 1'b0;
    above_short_level[0] = 1'b1;
    short_circuit_clear[0] = 1'b1;
    @(negedge clk);
    short_circuit_clear[0] = 1'b0;
    chk(short_circuit_flag[0], 1'b0);
    @(negedge clk);
    chk(irq_out_n, 1'b1);
  endtask : t_short

  task automatic t_pg();
    core_enable_bit[1] = 1'b1;
    output_power_good[1] = 1'b1;
    cyc(3);
    chk(power_good_flag[1], 1'b1);
    chk(irq_out_n, 1'b0);
    power_good_mask[1] = 1'b1;
    cyc(2);
    chk(irq_out_n, 1'b1);
    power_good_clear[1] = 1'b1;
    @(negedge clk);
    power_good_clear[1] = 1'b0;
    chk(power_good_flag[1], 1'b0);
    power_good_mask[1] = 1'b0;
    output_power_good[1] = 1'b0;
  endtask : t_pg

  task automatic t_soft();
    soft_reset_bit = 1'b1;
    @(negedge clk);
    soft_reset_bit = 1'b0;
    chk(core_on, 4'h0);
    chk({otp_load, defaults_load, interface_enable}, 3'h7);
    wait_up(16);
  endtask : t_soft

  task automatic t_resets();
    for (int s = 0; s < 3; s++)
    begin
      core_enable_bit[1] = 1'b1;
      cyc(2);
      reset_in_n = (s != 0);
      analog_supply = (s != 1);
      fault_shutdown = (s == 2);
      cyc(2);
      chk({core_on, interface_enable}, 5'h00);
      reset_in_n = 1'b1;
      analog_supply = 1'b1;
      fault_shutdown = 1'b0;
      wait_up(1017);
    end
  endtask : t_resets

  task automatic summarize();
    if (err_total == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize

  initial
  begin
    cyc(3);
    rst_n = 1'b1;
    wait_up(1017);
    t_pulldown();
    t_reg();
    t_pin();
    t_roof();
    t_short();
    t_pg();
    t_soft();
    t_resets();
    summarize();
  end

  initial
  begin
    #600000;
    err_total++;
    summarize();
  end
endmodule : tb
